//--- src/dbpm_pkg.sv
// Constants and types shared by the drop bus phase marker block.
// Assumes nothing of its surroundings; imported by scope only.
`default_nettype none

package dbpm_pkg;
    localparam int NUM_CHAN = 4;
    localparam int DATA_W = 8;
    localparam int WORD_W = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int POS_TOH = 8;
    localparam int POS_C1 = 9;
    localparam int POS_J1 = 10;
    localparam int POS_FIRST = 11;
    localparam int FRAMER_CHAN_BASE = 8;
    localparam int SYNC_W = 3;
    localparam int CFG_TBUS = 0;
    localparam int CFG_FRAMER = 1;
    localparam int CFG_BYPASS = 2;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic BIT_RESET = 1'b0;
    localparam logic [2:0] CFG_RESET = 3'h0;

    typedef enum {MODE_IDLE, MODE_BUS, MODE_FRAMER} dbpm_mode_t;
endpackage

`default_nettype wire

//--- src/dbpm_fifo_if.sv
// Carrier between a channel's write logic, its FIFO and its drop-side drain.
// Assumes the write group lives on the system clock, the read group on the drop clock.
`default_nettype none

interface dbpm_fifo_if #(parameter int W = 12);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;

    modport fifo (input wr_valid, input wr_data, input rd_ready,
                  output wr_ready, output rd_valid, output rd_data);
    modport user (output wr_valid, output wr_data, output rd_ready,
                  input wr_ready, input rd_valid, input rd_data);
endinterface

`default_nettype wire

//--- src/dbpm_fifo.sv
// Dual-clock FIFO with gray-coded pointers and a registered read word.
// Assumes each reset is synchronous to and held in its own domain.
`default_nettype none

module dbpm_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic wr_clk,
    input wire logic wr_rst_n,
    input wire logic rd_clk,
    input wire logic rd_rst_n,
    dbpm_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin;
    logic [AW:0] wgray;
    logic [AW:0] rq1;
    logic [AW:0] rq2;
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] wq1;
    logic [AW:0] wq2;

    wire wr_fire = port.wr_valid & port.wr_ready;
    wire [AW:0] next_wbin = wbin + {{AW{1'b0}}, wr_fire};
    wire [AW:0] next_wgray = (next_wbin >> 1) ^ next_wbin;
    wire next_full = next_wgray == {~rq2[AW:AW-1], rq2[AW-2:0]};
    wire empty = rgray == wq2;
    wire load = ~empty & (~port.rd_valid | port.rd_ready);
    wire [AW:0] next_rbin = rbin + {{AW{1'b0}}, load};
    wire [AW:0] next_rgray = (next_rbin >> 1) ^ next_rbin;

    always_ff @(posedge wr_clk) begin
        if (!wr_rst_n) begin
            wbin <= '0;
            wgray <= '0;
            rq1 <= '0;
            rq2 <= '0;
            port.wr_ready <= 1'b0;
        end else begin
            wbin <= next_wbin;
            wgray <= next_wgray;
            rq1 <= rgray;
            rq2 <= rq1;
            port.wr_ready <= ~next_full;
        end
    end

    // Memory has no reset so it maps to plain RAM
    always_ff @(posedge wr_clk) begin
        if (wr_fire) begin
            mem[wbin[AW-1:0]] <= port.wr_data;
        end
    end

    always_ff @(posedge rd_clk) begin
        if (!rd_rst_n) begin
            rbin <= '0;
            rgray <= '0;
            wq1 <= '0;
            wq2 <= '0;
            port.rd_valid <= 1'b0;
            port.rd_data <= '0;
        end else begin
            rbin <= next_rbin;
            rgray <= next_rgray;
            wq1 <= wgray;
            wq2 <= wq1;
            port.rd_valid <= load | (port.rd_valid & ~port.rd_ready);
            if (load) begin
                port.rd_data <= mem[rbin[AW-1:0]];
            end
        end
    end

    a_full_holds_ptr: assert property (@(posedge wr_clk) disable iff (!wr_rst_n)
        port.wr_valid && !port.wr_ready |=> wbin == $past(wbin))
        else $error("write pointer moved while full");

    a_word_held_stall: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
        port.rd_valid && !port.rd_ready |=> port.rd_valid && $stable(port.rd_data))
        else $error("read word lost while stalled");
endmodule

`default_nettype wire

//--- src/dbpm_top.sv
// Four-channel drop-side phase marker: bytes or tributary bits enter on CLK,
// cross a FIFO per channel and leave on that channel's drop clock.
// Assumes config levels come from CLK logic and each drop clock runs while used.
`default_nettype none

module dbpm_top (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [3:0] TBUS_ENABLE,
    input wire logic [3:0] FRAMER_ENABLE,
    input wire logic [3:0] FRAMER_BYPASS,
    input wire logic [3:0] IN_VALID,
    output wire logic [3:0] IN_READY,
    input wire logic [3:0][7:0] IN_DATA,
    input wire logic [3:0] IN_TOH,
    input wire logic [3:0] IN_C1,
    input wire logic [3:0] IN_J1,
    input wire logic [3:0] IN_FIRST,
    input wire logic [3:0] DROP_CLK,
    output wire logic [3:0][7:0] DROP_DATA,
    output wire logic [3:0] DROP_PAYLOAD,
    output wire logic [3:0] DROP_PHASE_MARKER,
    output wire logic [3:0] TRIB_SERIAL_OUT
);
    genvar c;

    generate
        for (c = 0; c < dbpm_pkg::NUM_CHAN; c++) begin : g_chan
            // Pin c doubles as frame pulse of framer channel c plus eight
            localparam int FRAMER_CHAN = c + dbpm_pkg::FRAMER_CHAN_BASE;

            dbpm_fifo_if #(.W(dbpm_pkg::WORD_W)) link ();

            logic rst_q1;
            logic drop_rst_n;
            logic [dbpm_pkg::SYNC_W-1:0] cfg_q1;
            logic [dbpm_pkg::SYNC_W-1:0] cfg_q2;
            dbpm_pkg::dbpm_mode_t mode;
            dbpm_pkg::dbpm_mode_t next_mode;
            logic [7:0] data;
            logic payload;
            logic marker;
            logic serial;
            logic [7:0] next_data;
            logic next_payload;
            logic next_marker;
            logic next_serial;

            // Write side stays on CLK; the FIFO does the only word crossing
            assign link.wr_valid = IN_VALID[c];
            assign link.wr_data = {IN_FIRST[c], IN_J1[c], IN_C1[c], IN_TOH[c], IN_DATA[c]};
            assign IN_READY[c] = link.wr_ready;

            dbpm_fifo #(
                .WIDTH(dbpm_pkg::WORD_W),
                .DEPTH(dbpm_pkg::FIFO_DEPTH)
            ) u_fifo (
                .wr_clk(CLK),
                .wr_rst_n(RESET_N),
                .rd_clk(DROP_CLK[c]),
                .rd_rst_n(drop_rst_n),
                .port(link)
            );

            // Reset reaches the drop domain through two flops
            always_ff @(posedge DROP_CLK[c]) begin
                rst_q1 <= RESET_N;
                drop_rst_n <= rst_q1;
            end

            wire [dbpm_pkg::SYNC_W-1:0] cfg_in = {FRAMER_BYPASS[c], FRAMER_ENABLE[c],
                                                   TBUS_ENABLE[c]};

            // Config is static in use, so a level synchroniser is enough
            always_ff @(posedge DROP_CLK[c]) begin
                if (!drop_rst_n) begin
                    cfg_q1 <= dbpm_pkg::CFG_RESET;
                    cfg_q2 <= dbpm_pkg::CFG_RESET;
                end else begin
                    cfg_q1 <= cfg_in;
                    cfg_q2 <= cfg_q1;
                end
            end

            wire tbus_on = cfg_q2[dbpm_pkg::CFG_TBUS];
            wire framer_on = cfg_q2[dbpm_pkg::CFG_FRAMER];
            wire bypass_on = cfg_q2[dbpm_pkg::CFG_BYPASS];

            // Bus enable decides the pin's role; framer only when bus is off
            assign next_mode = tbus_on ? dbpm_pkg::MODE_BUS :
                               framer_on ? dbpm_pkg::MODE_FRAMER : dbpm_pkg::MODE_IDLE;

            // With both roles off the drain stalls and the FIFO fills
            assign link.rd_ready = mode != dbpm_pkg::MODE_IDLE;
            wire pop = link.rd_valid & link.rd_ready;
            // Role-qualified pops, shared by the checks below
            wire bus_pop = pop & (mode == dbpm_pkg::MODE_BUS);
            wire frm_pop = pop & (mode == dbpm_pkg::MODE_FRAMER);

            wire [7:0] w_data = link.rd_data[7:0];
            wire w_toh = link.rd_data[dbpm_pkg::POS_TOH];
            wire w_c1 = link.rd_data[dbpm_pkg::POS_C1];
            wire w_j1 = link.rd_data[dbpm_pkg::POS_J1];
            wire w_first = link.rd_data[dbpm_pkg::POS_FIRST];

            // C1 is overhead and J1 is not, whatever the overhead flag says
            wire bus_payload = w_c1 ? 1'b0 : (w_j1 ? 1'b1 : ~w_toh);

            always_comb begin
                next_data = dbpm_pkg::DATA_RESET;
                next_payload = dbpm_pkg::BIT_RESET;
                next_marker = dbpm_pkg::BIT_RESET;
                next_serial = dbpm_pkg::BIT_RESET;
                case (mode)
                    dbpm_pkg::MODE_BUS: begin
                        if (pop) begin
                            next_data = w_data;
                            next_payload = bus_payload;
                            next_marker = w_c1 | w_j1;
                        end
                    end
                    dbpm_pkg::MODE_FRAMER: begin
                        if (pop) begin
                            next_serial = w_data[0];
                            next_marker = w_first & ~bypass_on;
                        end
                    end
                    dbpm_pkg::MODE_IDLE: begin
                        next_marker = dbpm_pkg::BIT_RESET;
                    end
                    default: begin
                        next_marker = dbpm_pkg::BIT_RESET;
                    end
                endcase
            end

            // One edge updates data, indicator and marker together
            always_ff @(posedge DROP_CLK[c]) begin
                if (!drop_rst_n) begin
                    mode <= dbpm_pkg::MODE_IDLE;
                    data <= dbpm_pkg::DATA_RESET;
                    payload <= dbpm_pkg::BIT_RESET;
                    marker <= dbpm_pkg::BIT_RESET;
                    serial <= dbpm_pkg::BIT_RESET;
                end else begin
                    mode <= next_mode;
                    data <= next_data;
                    payload <= next_payload;
                    marker <= next_marker;
                    serial <= next_serial;
                end
            end

            assign DROP_DATA[c] = data;
            assign DROP_PAYLOAD[c] = payload;
            assign DROP_PHASE_MARKER[c] = marker;
            assign TRIB_SERIAL_OUT[c] = serial;

            a_c1_pl_low: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && w_c1 |=> marker && !payload)
                else $error("C1 not marked with payload low");

            a_j1_pl_high: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && w_j1 && !w_c1 |=> marker && payload)
                else $error("J1 not marked with payload high");

            a_marker_has_cause: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                $rose(marker) |-> $past(pop) && $past(w_c1 || w_j1 || w_first))
                else $error("marker without a marked byte or bit");

            a_marker_one_period: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                marker ##1 !$past(pop) |-> !marker)
                else $error("marker outlived its byte");

            a_frame_pulse_bit: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                frm_pop && w_first && !bypass_on |=> marker && serial == $past(w_data[0]))
                else $error("frame pulse not aligned with first bit");

            a_bypass_quiet: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                mode == dbpm_pkg::MODE_FRAMER && bypass_on |=> !marker)
                else $error("frame pulse while bypassed");

            a_toh_pl_low: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop |=> payload == (!$past(w_c1) && ($past(w_j1) || !$past(w_toh))))
                else $error("payload indicator wrong for byte kind");

            a_same_edge: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop |=> data == $past(w_data) && marker == $past(w_c1 || w_j1))
                else $error("data and marker not on the same edge");

            a_role_select: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                mode != dbpm_pkg::MODE_BUS |=> data == dbpm_pkg::DATA_RESET && !payload)
                else $error("bus outputs active outside bus role");

            a_idle_stalls: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                mode == dbpm_pkg::MODE_IDLE |-> !pop ##1 !marker && !serial)
                else $error("drain active with both roles off");

            a_bus_wins: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                tbus_on |=> mode == dbpm_pkg::MODE_BUS)
                else $error("bus enable did not select the bus role");

            a_framer_role: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                !tbus_on && framer_on |=> mode == dbpm_pkg::MODE_FRAMER)
                else $error("framer role not selected with bus off");

            a_no_role: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                !tbus_on && !framer_on |=> mode == dbpm_pkg::MODE_IDLE)
                else $error("a role was selected with both enables off");

            a_bus_no_serial: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                mode == dbpm_pkg::MODE_BUS |=> !serial)
                else $error("serial output active in bus role");

            a_serial_in_framer: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                serial |-> $past(mode == dbpm_pkg::MODE_FRAMER))
                else $error("serial bit outside framer role");

            a_c1_byte_out: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && w_c1 |=> data == $past(w_data))
                else $error("C1 byte not on the data bus with its marker");

            a_plain_no_mark: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && !w_c1 && !w_j1 |=> !marker)
                else $error("marker on an unmarked byte");

            a_j1_byte_out: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && w_j1 |=> data == $past(w_data))
                else $error("J1 byte not on the data bus with its marker");

            a_c1_one_cycle: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && w_c1 ##1 !pop |=> !marker)
                else $error("C1 marker longer than one period");

            a_j1_one_cycle: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && w_j1 ##1 !pop |=> !marker)
                else $error("J1 marker longer than one period");

            a_j1_not_toh: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && w_j1 && w_toh && !w_c1 |=> payload)
                else $error("J1 shown with payload indicator low");

            a_first_bit_out: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                frm_pop |=> serial == $past(w_data[0]))
                else $error("serial bit not driven from its word");

            a_pulse_one_bit: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                frm_pop && w_first && !bypass_on ##1 !pop |=> !marker)
                else $error("frame pulse longer than one bit");

            a_no_first_quiet: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                frm_pop && !w_first |=> !marker)
                else $error("frame pulse on a later bit");

            a_bypass_flows: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                frm_pop && bypass_on |=> serial == $past(w_data[0]))
                else $error("serial data stopped while bypassed");

            a_toh_byte_low: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                bus_pop && w_toh && !w_j1 |=> !payload)
                else $error("overhead byte shown as payload");

            a_payload_in_bus: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                payload |-> $past(mode == dbpm_pkg::MODE_BUS))
                else $error("payload indicator high outside bus role");

            a_empty_quiet: assert property (
                @(posedge DROP_CLK[c]) disable iff (!drop_rst_n)
                !pop |=> !marker && !serial && !payload && data == dbpm_pkg::DATA_RESET)
                else $error("outputs active without a word");
        end
    endgenerate
endmodule

`default_nettype wire

//--- dv/dbpm_drop_rx.sv
// Drop-side receiver model: logs every non-idle drop cycle of each channel.
// Assumes the block's drop outputs change just after the drop clock rising edge.
`default_nettype none

module dbpm_drop_rx (
    input wire logic [3:0] drop_clk,
    input wire logic [3:0][7:0] drop_data,
    input wire logic [3:0] drop_payload,
    input wire logic [3:0] drop_marker,
    input wire logic [3:0] serial
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle cycles are all zero, so only non-zero cycles are kept
    logic [10:0] log [4][$];
    for (genvar c = 0; c < 4; c++) begin : g_ch
        // Marker, indicator and data are taken together on one edge
        always @(posedge drop_clk[c]) begin
            if (drop_marker[c] || drop_payload[c] || serial[c] || drop_data[c] != 8'h00) begin
                log[c].push_back({serial[c], drop_marker[c], drop_payload[c], drop_data[c]});
            end
        end
    end
endmodule

`default_nettype wire

//--- dv/dbpm_top_bench.sv
// Self-checking bench of the drop bus phase marker block.
// Assumes free-running 30 ns drop clocks and the drop receiver model.
`default_nettype none

module dbpm_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [3:0] TBUS_ENABLE = 4'h0;
    logic [3:0] FRAMER_ENABLE = 4'h0;
    logic [3:0] FRAMER_BYPASS = 4'h0;
    logic [3:0] IN_VALID = 4'h0;
    logic [3:0][7:0] IN_DATA = '0;
    logic [3:0] IN_TOH = 4'h0;
    logic [3:0] IN_C1 = 4'h0;
    logic [3:0] IN_J1 = 4'h0;
    logic [3:0] IN_FIRST = 4'h0;
    logic [3:0] DROP_CLK = 4'h0;
    wire logic [3:0] IN_READY;
    wire logic [3:0][7:0] DROP_DATA;
    wire logic [3:0] DROP_PAYLOAD;
    wire logic [3:0] DROP_PHASE_MARKER;
    wire logic [3:0] TRIB_SERIAL_OUT;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;

    dbpm_top i_dut (.CLK(CLK), .RESET_N(RESET_N), .TBUS_ENABLE(TBUS_ENABLE),
        .FRAMER_ENABLE(FRAMER_ENABLE), .FRAMER_BYPASS(FRAMER_BYPASS), .IN_VALID(IN_VALID),
        .IN_READY(IN_READY), .IN_DATA(IN_DATA), .IN_TOH(IN_TOH), .IN_C1(IN_C1),
        .IN_J1(IN_J1), .IN_FIRST(IN_FIRST), .DROP_CLK(DROP_CLK), .DROP_DATA(DROP_DATA),
        .DROP_PAYLOAD(DROP_PAYLOAD), .DROP_PHASE_MARKER(DROP_PHASE_MARKER),
        .TRIB_SERIAL_OUT(TRIB_SERIAL_OUT));
    dbpm_drop_rx i_rx (.drop_clk(DROP_CLK), .drop_data(DROP_DATA), .drop_payload(DROP_PAYLOAD),
        .drop_marker(DROP_PHASE_MARKER), .serial(TRIB_SERIAL_OUT));

    always #5 CLK = ~CLK;
    for (genvar c = 0; c < 4; c++) begin : g_dclk
        // Odd offsets keep each drop clock out of step with CLK
        initial begin
            #(1.3 + 4.1 * c);
            forever #15 DROP_CLK[c] = ~DROP_CLK[c];
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Flags are {first, j1, c1, toh}; the word is held until the ready edge
    task automatic push(input int ch, input logic [7:0] d, input logic [3:0] f);
        int n;
        logic r;
        n = 0;
        r = 1'b0;
        #1;
        IN_VALID[ch] = 1'b1;
        IN_DATA[ch] = d;
        {IN_FIRST[ch], IN_J1[ch], IN_C1[ch], IN_TOH[ch]} = f;
        while (!r && n < 100) begin
            @(negedge CLK);
            r = IN_READY[ch];
            @(posedge CLK);
            n++;
        end
    endtask

    task automatic idle(input int ch);
        #1;
        IN_VALID[ch] = 1'b0;
    endtask

    // Config crosses two flops plus a mode register, so allow a margin
    task automatic cfg(input int ch, input logic t, input logic f, input logic b);
        i_rx.log[ch].delete();
        @(posedge CLK);
        #1;
        TBUS_ENABLE[ch] = t;
        FRAMER_ENABLE[ch] = f;
        FRAMER_BYPASS[ch] = b;
        repeat (12) @(posedge DROP_CLK[ch]);
        @(posedge CLK);
    endtask

    task automatic settle(input int ch, input int n);
        int k;
        k = 0;
        while (i_rx.log[ch].size() < n && k < 400) begin
            @(posedge CLK);
            k++;
        end
        repeat (10) @(posedge DROP_CLK[ch]);
        check(11'(i_rx.log[ch].size()), 11'(n));
    endtask

    task automatic bus_test(input int ch);
        logic [3:0] fl [5] = '{4'b0001, 4'b0011, 4'b0000, 4'b0100, 4'b0000};
        logic [1:0] mp [5] = '{2'b00, 2'b10, 2'b01, 2'b11, 2'b01};
        // Odd channels enable the framer as well; the bus role must still win
        cfg(ch, 1'b1, 1'(ch % 2), 1'b0);
        for (int k = 0; k < 5; k++) push(ch, 8'(ch * 16 + k + 1), fl[k]);
        idle(ch);
        settle(ch, 5);
        for (int k = 0; k < 5; k++) begin
            check(i_rx.log[ch][k], {1'b0, mp[k], 8'(ch * 16 + k + 1)});
        end
    endtask

    task automatic framer_test(input int ch, input logic byp);
        cfg(ch, 1'b0, 1'b1, byp);
        for (int k = 0; k < 4; k++) push(ch, 8'h01, (k == 0) ? 4'b1000 : 4'b0000);
        idle(ch);
        settle(ch, 4);
        for (int k = 0; k < 4; k++) begin
            check(i_rx.log[ch][k], {1'b1, (k == 0 && !byp), 9'h000});
        end
    endtask

    // Both roles off stalls the drain: 32 stored words plus the held read word
    task automatic fill_test();
        int n;
        logic r;
        n = 0;
        cfg(0, 1'b0, 1'b0, 1'b0);
        #1;
        IN_VALID[0] = 1'b1;
        IN_DATA[0] = 8'h41;
        {IN_FIRST[0], IN_J1[0], IN_C1[0], IN_TOH[0]} = 4'h0;
        for (int k = 0; k < 40; k++) begin
            @(negedge CLK);
            r = IN_READY[0];
            @(posedge CLK);
            if (r) n++;
            #1;
            IN_DATA[0] = 8'(8'h41 + n);
        end
        check(11'(n), 11'(dbpm_pkg::FIFO_DEPTH + 1));
        check({10'h000, IN_READY[0]}, 11'h000);
        IN_VALID[0] = 1'b0;
        cfg(0, 1'b1, 1'b0, 1'b0);
        settle(0, dbpm_pkg::FIFO_DEPTH + 1);
        for (int k = 0; k <= dbpm_pkg::FIFO_DEPTH; k++) begin
            check(i_rx.log[0][k], {3'b001, 8'(8'h41 + k)});
        end
        check({IN_READY[0], 2'b00, DROP_DATA[0]}, 11'h400);
    endtask

    initial begin
        repeat (8) @(posedge CLK);
        #1;
        RESET_N = 1'b1;
        repeat (10) @(posedge CLK);
        for (int c = 0; c < 4; c++) bus_test(c);
        for (int c = 0; c < 4; c++) framer_test(c, 1'b0);
        for (int c = 0; c < 4; c++) framer_test(c, 1'b1);
        fill_test();
        stop_test();
    end
endmodule

`default_nettype wire
